// File: mii_strap_params.svh
// constants for the strap-latching pin block of the media interface
// assumes one core clock and one link clock feeding the pin logic
// What this block does
// - latch duplex from rxd0; then drive rxd0
// - latch mode bit 2 from rx_dv; then drive rx_dv
// - latch broadcast-off from rx_clk; then drive rx_clk
// - latch detach from rx_er; then drive rx_er
// - interrupt pin only pulls low or releases
// - latch pin-chain test (active low) from irq pin
// - control bit overrides tx_clk sampled high
// - device drives tx_clk; mac data follows it
// - transmit nibble taken only while enable high
// - latch mode bit 0 from col; then drive col
// - latch mode bit 1 from crs; then drive crs
// - rx nibble follows rx_clk, valid with rx_dv
// - strap pins inputs during reset, outputs after latch; detach keeps all but the irq pin inputs
`ifndef MII_STRAP_PARAMS_SVH
`define MII_STRAP_PARAMS_SVH

// ********************************
// pin positions in the sampled vector
// ********************************
`define PIN_COUNT    8
`define PIN_RXD0     0
`define PIN_RX_DV    1
`define PIN_RX_CLK   2
`define PIN_RX_ER    3
`define PIN_COL      4
`define PIN_CRS      5
`define PIN_IRQ      6
`define PIN_TX_CLK   7

// ********************************
// timing and reset values
// ********************************
`define SETTLE_LAST  2'h2
`define SETTLE_RESET 2'h0
`define NIBBLE_ZERO  4'h0
`define TX_SYNC_BITS 5
`define RUN_BITS     2

`endif

// File: mii_strap_pkg.sv
// types shared by the strap-latching pin block
// assumes mii_strap_params.svh is compiled alongside
package mii_strap_pkg;

    // ********************************
    // strap sequencer states
    // ********************************
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_LATCH  = 2'b01,
        ST_RUN    = 2'b10
    } strap_state_type;

    // ********************************
    // latched strap values
    // ********************************
    typedef struct packed {
        logic       duplex;
        logic [2:0] mode;
        logic       bcast_addr_disable;
        logic       mii_detach;
        logic       pin_chain_test_n;
        logic       tx_clk_high;
    } strap_set_type;

endpackage

// File: bit_sync.sv
// two-stage synchroniser for a group of levels
// assumes each bit is a level, not a pulse
`timescale 1ns/100ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] safe;
    } sync_state_type;

    sync_state_type cur;
    sync_state_type next_cur;

    // first stage feeds only the second
    always_comb begin
        next_cur      = cur;
        next_cur.meta = d;
        next_cur.safe = cur.meta;
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign q = cur.safe;
endmodule // bit_sync

// File: tx_capture.sv
// transmit nibble capture on the link clock
// assumes tick marks the link edge where tx_clk rises
`timescale 1ns/100ps
`include "mii_strap_params.svh"
module tx_capture (
    input  wire logic       line_clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic       tx_en_i,
    input  wire logic [3:0] txd_i,
    output logic      [3:0] tx_nibble,
    output logic            tx_nibble_valid
);
    typedef struct packed {
        logic [3:0] nibble;
        logic       valid;
    } cap_state_type;

    cap_state_type                     cur;
    cap_state_type                     next_cur;
    logic          [`TX_SYNC_BITS-1:0] pins;

    // pin inputs pass two flops first
    bit_sync #(.WIDTH(`TX_SYNC_BITS)) u_sync (
        .clk   (line_clk),
        .rst_n (rst_n),
        .d     ({tx_en_i, txd_i}),
        .q     (pins)
    );

    // data only looked at while enable is high
    always_comb begin
        next_cur       = cur;
        next_cur.valid = 1'b0;
        if (tick && enable && pins[4]) begin
            next_cur.nibble = pins[3:0];
            next_cur.valid  = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge line_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tx_nibble       = cur.nibble;
    assign tx_nibble_valid = cur.valid;
endmodule // tx_capture

// File: mii_pins_with_reset_straps.sv
// media interface pins of the phy with straps caught at reset release
// assumes core_clk runs free; line_clk is the phy's own link clock
`timescale 1ns/100ps
`include "mii_strap_params.svh"
module mii_pins_with_reset_straps (
    input  wire logic       core_clk,
    input  wire logic       line_clk,
    input  wire logic       arst_n,
    // receive data and strap pins
    input  wire logic       rxd0_i,
    output logic      [3:0] rxd_o,
    output logic            rxd_oe,
    input  wire logic       rx_dv_i,
    output logic            rx_dv_o,
    output logic            rx_dv_oe,
    input  wire logic       rx_clk_i,
    output logic            rx_clk_o,
    output logic            rx_clk_oe,
    input  wire logic       rx_er_i,
    output logic            rx_er_o,
    output logic            rx_er_oe,
    input  wire logic       col_i,
    output logic            col_o,
    output logic            col_oe,
    input  wire logic       crs_i,
    output logic            crs_o,
    output logic            crs_oe,
    input  wire logic       irq_out_i,
    output logic            irq_out_o,
    output logic            irq_out_oe,
    // transmit pins
    input  wire logic       tx_clk_i,
    output logic            tx_clk_o,
    output logic            tx_clk_oe,
    input  wire logic       tx_en_i,
    input  wire logic [3:0] txd_i,
    // link-side user ports, line_clk domain
    input  wire logic [3:0] rx_nibble_in,
    input  wire logic       rx_valid_in,
    input  wire logic       rx_error_in,
    output logic            rx_take,
    output logic      [3:0] tx_nibble,
    output logic            tx_nibble_valid,
    // core-side user ports, core_clk domain
    input  wire logic       col_in,
    input  wire logic       crs_in,
    input  wire logic       irq_request,
    input  wire logic       tx_clk_fix,
    output logic            duplex,
    output logic            mode_strap_b0,
    output logic            mode_strap_b1,
    output logic            mode_strap_b2,
    output logic            bcast_addr_disable,
    output logic            mii_detach,
    output logic            pin_chain_test_n,
    output logic            tx_clk_strap_high,
    output logic            straps_valid
);

    // ********************************
    // core domain state
    // ********************************
    typedef struct packed {
        mii_strap_pkg::strap_state_type state;
        logic [1:0]                     settle;
        mii_strap_pkg::strap_set_type   straps;
        logic                           valid;
        logic                           pins_on;
        logic                           col;
        logic                           crs;
        logic                           irq_pull;
        logic                           rx_run;
        logic                           tx_run;
    } core_state_type;

    // ********************************
    // link domain state
    // ********************************
    typedef struct packed {
        logic       rx_clk;
        logic       tx_clk;
        logic [3:0] rxd;
        logic       rx_dv;
        logic       rx_er;
        logic       take;
    } line_state_type;

    core_state_type                 core;
    core_state_type                 next_core;
    line_state_type                 line;
    line_state_type                 next_line;
    logic           [`PIN_COUNT-1:0] pin_raw;
    logic           [`PIN_COUNT-1:0] pin_lvl;
    logic           [`RUN_BITS-1:0]  run_line;

    // strap pins sampled through two flops
    assign pin_raw[`PIN_RXD0]   = rxd0_i;
    assign pin_raw[`PIN_RX_DV]  = rx_dv_i;
    assign pin_raw[`PIN_RX_CLK] = rx_clk_i;
    assign pin_raw[`PIN_RX_ER]  = rx_er_i;
    assign pin_raw[`PIN_COL]    = col_i;
    assign pin_raw[`PIN_CRS]    = crs_i;
    assign pin_raw[`PIN_IRQ]    = irq_out_i;
    assign pin_raw[`PIN_TX_CLK] = tx_clk_i;

    bit_sync #(.WIDTH(`PIN_COUNT)) u_pin_sync (
        .clk   (core_clk),
        .rst_n (arst_n),
        .d     (pin_raw),
        .q     (pin_lvl)
    );

    // ********************************
    // strap sequencer and core outputs
    // ********************************

    // wait for the synchroniser to fill, latch once, then run
    always_comb begin
        next_core = core;
        case (core.state)
            mii_strap_pkg::ST_SETTLE: begin
                if (core.settle == `SETTLE_LAST) begin
                    next_core.state = mii_strap_pkg::ST_LATCH;
                end else begin
                    next_core.settle = core.settle + 2'h1;
                end
            end
            mii_strap_pkg::ST_LATCH: begin
                // all straps taken in this one cycle
                next_core.straps.duplex =
                    pin_lvl[`PIN_RXD0];
                next_core.straps.mode[2] =
                    pin_lvl[`PIN_RX_DV];
                next_core.straps.bcast_addr_disable =
                    pin_lvl[`PIN_RX_CLK];
                next_core.straps.mii_detach =
                    pin_lvl[`PIN_RX_ER];
                next_core.straps.pin_chain_test_n =
                    pin_lvl[`PIN_IRQ];
                next_core.straps.mode[0] =
                    pin_lvl[`PIN_COL];
                next_core.straps.mode[1] =
                    pin_lvl[`PIN_CRS];
                next_core.straps.tx_clk_high =
                    pin_lvl[`PIN_TX_CLK];
                next_core.valid = 1'b1;
                next_core.state = mii_strap_pkg::ST_RUN;
            end
            mii_strap_pkg::ST_RUN: begin
                next_core.state = mii_strap_pkg::ST_RUN;
            end
            default: begin
                next_core.state = mii_strap_pkg::ST_SETTLE;
            end
        endcase

        // pins turn to outputs only after latching, unless detached; the irq pull needs latching only
        next_core.pins_on = next_core.valid
                          & ~next_core.straps.mii_detach;
        next_core.rx_run  = next_core.pins_on;
        // tx path blocked when tx_clk strapped high, unless fixed
        next_core.tx_run  = next_core.pins_on
                          & (~next_core.straps.tx_clk_high
                             | tx_clk_fix);
        next_core.col      = col_in & next_core.pins_on;
        next_core.crs      = crs_in & next_core.pins_on;
        next_core.irq_pull = irq_request & next_core.valid;
    end

    // core registers; only constants under reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            core        <= '0;
            core.state  <= mii_strap_pkg::ST_SETTLE;
            core.settle <= `SETTLE_RESET;
        end else begin
            core <= next_core;
        end
    end

    // run enables cross to the link clock as levels
    bit_sync #(.WIDTH(`RUN_BITS)) u_run_sync (
        .clk   (line_clk),
        .rst_n (arst_n),
        .d     ({core.tx_run, core.rx_run}),
        .q     (run_line)
    );

    // ********************************
    // link domain: clocks and rx nibble
    // ********************************

    // mii clocks at half the link rate; rx data moves on rx_clk fall
    always_comb begin
        next_line        = line;
        next_line.rx_clk = ~line.rx_clk;
        next_line.tx_clk = ~line.tx_clk;
        next_line.take   = 1'b0;
        if (line.rx_clk) begin
            next_line.take = 1'b1;
            if (run_line[0] && rx_valid_in) begin
                next_line.rxd   = rx_nibble_in;
                next_line.rx_dv = 1'b1;
                next_line.rx_er = rx_error_in;
            end else begin
                next_line.rxd   = `NIBBLE_ZERO;
                next_line.rx_dv = 1'b0;
                next_line.rx_er = 1'b0;
            end
        end
    end

    // link registers
    always_ff @(posedge line_clk or negedge arst_n) begin
        if (!arst_n) begin
            line <= '0;
        end else begin
            line <= next_line;
        end
    end

    // tx nibble taken at the link edge where tx_clk rises
    tx_capture u_tx (
        .line_clk        (line_clk),
        .rst_n           (arst_n),
        .enable          (run_line[1]),
        .tick            (~line.tx_clk),
        .tx_en_i         (tx_en_i),
        .txd_i           (txd_i),
        .tx_nibble       (tx_nibble),
        .tx_nibble_valid (tx_nibble_valid)
    );

    // ********************************
    // pin drive
    // ********************************

    // receive group, driven only after reset and straps
    assign rxd_o     = line.rxd;
    assign rxd_oe    = core.pins_on;
    assign rx_dv_o   = line.rx_dv;
    assign rx_dv_oe  = core.pins_on;
    assign rx_clk_o  = line.rx_clk;
    assign rx_clk_oe = core.pins_on;
    assign rx_er_o   = line.rx_er;
    assign rx_er_oe  = core.pins_on;
    assign col_o     = core.col;
    assign col_oe    = core.pins_on;
    assign crs_o     = core.crs;
    assign crs_oe    = core.pins_on;
    assign rx_take   = line.take;

    // open drain: output low, enable pulls
    assign irq_out_o  = 1'b0;
    assign irq_out_oe = core.irq_pull;

    // device sources the transmit clock
    assign tx_clk_o  = line.tx_clk;
    assign tx_clk_oe = core.pins_on;

    // strap values held until the next reset
    assign duplex             = core.straps.duplex;
    assign mode_strap_b0      = core.straps.mode[0];
    assign mode_strap_b1      = core.straps.mode[1];
    assign mode_strap_b2      = core.straps.mode[2];
    assign bcast_addr_disable = core.straps.bcast_addr_disable;
    assign mii_detach         = core.straps.mii_detach;
    assign pin_chain_test_n   = core.straps.pin_chain_test_n;
    assign tx_clk_strap_high  = core.straps.tx_clk_high;
    assign straps_valid       = core.valid;

endmodule // mii_pins_with_reset_straps

// File: mii_pins_asserts.sv
// checker for the strap-latching media pin block
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/100ps
module mii_pins_asserts (
    input wire logic       core_clk,
    input wire logic       line_clk,
    input wire logic       arst_n,
    input wire logic [3:0] rxd_o,
    input wire logic       rxd_oe,
    input wire logic       rx_dv_o,
    input wire logic       rx_clk_o,
    input wire logic       col_o,
    input wire logic       col_oe,
    input wire logic       irq_out_o,
    input wire logic       irq_out_oe,
    input wire logic       tx_clk_o,
    input wire logic       tx_clk_oe,
    input wire logic       tx_en_i,
    input wire logic [3:0] txd_i,
    input wire logic [3:0] rx_nibble_in,
    input wire logic       rx_valid_in,
    input wire logic       rx_take,
    input wire logic [3:0] tx_nibble,
    input wire logic       tx_nibble_valid,
    input wire logic       col_in,
    input wire logic       irq_request,
    input wire logic       mii_detach,
    input wire logic       tx_clk_strap_high,
    input wire logic       straps_valid
);
    logic [2:0] since;

    // ************************************
    // core edges since reset release
    // ************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            since <= 3'h0;
        end else if (since != 3'h7) begin
            since <= since + 3'h1;
        end
    end

    // receive offer and its answer one link edge later
    // data is taken at the edge where rx_clk falls; rx_take pulses at that same edge
    sequence rx_offer;
        rx_clk_o && !rx_take && rx_valid_in && $past(rxd_oe, 4);
    endsequence
    sequence rx_answer;
        rx_take && !rx_clk_o && rx_dv_o
            && rxd_o == $past(rx_nibble_in);
    endsequence

    AST_OE_NEED_STRAP: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (rxd_oe || col_oe || tx_clk_oe) |-> straps_valid && !mii_detach)
        else $error("pin driven outside run");
    AST_OE_ON_LATCH: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(straps_valid) && !mii_detach |-> rxd_oe && col_oe && tx_clk_oe)
        else $error("pins not enabled at latch");
    AST_STRAP_TIME: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        straps_valid == (since >= 3'h4))
        else $error("straps latched at wrong edge");
    AST_STRAP_HOLD: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        straps_valid |=> straps_valid
            && $stable({mii_detach, tx_clk_strap_high}))
        else $error("strap changed after latch");
    AST_IRQ_PIN: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !irq_out_o
            && irq_out_oe == ($past(irq_request) && straps_valid))
        else $error("interrupt pin not open drain");
    AST_COL_PIN: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $past(col_oe) |-> col_o == $past(col_in))
        else $error("collision pin wrong");
    AST_LINE_CLOCKS: assert property (
        @(posedge line_clk) disable iff (!arst_n)
        1'b1 |=> rx_clk_o != $past(rx_clk_o) && tx_clk_o != $past(tx_clk_o))
        else $error("link clocks not toggling");
    AST_RX_IDLE: assert property (
        @(posedge line_clk) disable iff (!arst_n)
        !rx_dv_o |-> rxd_o == 4'h0)
        else $error("receive data without valid");
    AST_RX_SAMPLE: assert property (
        @(posedge line_clk) disable iff (!arst_n)
        rx_offer |=> rx_answer)
        else $error("receive nibble wrong");
    AST_TX_TAKE: assert property (
        @(posedge line_clk) disable iff (!arst_n)
        tx_nibble_valid |-> $past(tx_en_i, 3) && tx_nibble == $past(txd_i, 3))
        else $error("transmit nibble wrong");
endmodule // mii_pins_asserts

bind mii_pins_with_reset_straps mii_pins_asserts mii_pins_asserts_inst (
    .core_clk, .line_clk, .arst_n, .rxd_o, .rxd_oe, .rx_dv_o, .rx_clk_o,
    .col_o, .col_oe, .irq_out_o, .irq_out_oe, .tx_clk_o, .tx_clk_oe,
    .tx_en_i, .txd_i, .rx_nibble_in, .rx_valid_in, .rx_take, .tx_nibble,
    .tx_nibble_valid, .col_in, .irq_request, .mii_detach,
    .tx_clk_strap_high, .straps_valid);

// File: mac_model.sv
// mac side of the media pins: board pulls and transmit source
// assumes pin drive and enable vectors come in strap bit order
`timescale 1ns/100ps
module mac_model (
    input  wire logic [7:0] strap,
    input  wire logic [7:0] drv,
    input  wire logic [7:0] oe,
    input  wire logic       send,
    output wire logic [7:0] pins,
    output logic            tx_en,
    output logic      [3:0] txd
);
    logic [3:0] count;

    // pin level: device drive, else board pull; tx clock pulled to strap bit 7
    assign pins = (oe & drv) | (~oe & strap);

    initial begin
        count = 4'h0;
        tx_en = 1'b0;
        txd = 4'h0;
    end

    // new nibble on each falling tx clock, odd ones with enable low
    always @(negedge pins[7]) begin
        count = count + 4'h1;
        txd <= count;
        tx_en <= send && !count[0];
    end
endmodule // mac_model

// File: mii_pins_with_reset_straps_test.sv
// testbench for the strap-latching media pin block
// assumes the checker is bound in and the mac model sits on the pins
`timescale 1ns/100ps
module mii_pins_with_reset_straps_test;
    logic       core_clk, line_clk, arst_n, rxd_oe, rx_dv_o, rx_dv_oe;
    logic       rx_clk_o, rx_clk_oe, rx_er_o, rx_er_oe, col_o, col_oe;
    logic       crs_o, crs_oe, irq_out_o, irq_out_oe, tx_clk_o, tx_clk_oe;
    logic       tx_en_i, rx_valid_in, rx_error_in, rx_take, send, duplex;
    logic       tx_nibble_valid, col_in, crs_in, irq_request, tx_clk_fix;
    logic       mode_strap_b0, mode_strap_b1, mode_strap_b2, mii_detach;
    logic       bcast_addr_disable, pin_chain_test_n, tx_clk_strap_high;
    logic       straps_valid;
    logic [3:0] rxd_o, txd_i, rx_nibble_in, tx_nibble;
    logic [7:0] strap;
    wire  [7:0] pins;
    int         err_count, n_tests;

    mii_pins_with_reset_straps mii_pins_with_reset_straps_inst (
        .core_clk, .line_clk, .arst_n, .rxd0_i(pins[0]), .rxd_o, .rxd_oe,
        .rx_dv_i(pins[1]), .rx_dv_o, .rx_dv_oe, .rx_clk_i(pins[2]),
        .rx_clk_o, .rx_clk_oe, .rx_er_i(pins[3]), .rx_er_o, .rx_er_oe,
        .col_i(pins[4]), .col_o, .col_oe, .crs_i(pins[5]), .crs_o, .crs_oe,
        .irq_out_i(pins[6]), .irq_out_o, .irq_out_oe, .tx_clk_i(pins[7]),
        .tx_clk_o, .tx_clk_oe, .tx_en_i, .txd_i, .rx_nibble_in,
        .rx_valid_in, .rx_error_in, .rx_take, .tx_nibble, .tx_nibble_valid,
        .col_in, .crs_in, .irq_request, .tx_clk_fix, .duplex, .mode_strap_b0,
        .mode_strap_b1, .mode_strap_b2, .bcast_addr_disable, .mii_detach,
        .pin_chain_test_n, .tx_clk_strap_high, .straps_valid);

    mac_model mac_model_inst (.strap, .send, .pins, .tx_en(tx_en_i),
        .txd(txd_i), .drv({tx_clk_o, irq_out_o, crs_o, col_o, rx_er_o,
        rx_clk_o, rx_dv_o, rxd_o[0]}), .oe({tx_clk_oe, irq_out_oe, crs_oe,
        col_oe, rx_er_oe, rx_clk_oe, rx_dv_oe, rxd_oe}));

    // ************************************
    // clocks and watchdog
    // ************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        line_clk = 1'b0;
        #7;
        forever #24 line_clk = ~line_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end

    // ************************************
    // compare, verdict, stimulus tasks
    // ************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] straps();
        return {tx_clk_strap_high, pin_chain_test_n, mode_strap_b1,
            mode_strap_b0, mii_detach, bcast_addr_disable, mode_strap_b2,
            duplex};
    endfunction

    task automatic drive_rx(input int k);
        rx_valid_in <= (k < 6) && (k != 2);
        rx_error_in <= (k == 4);
        rx_nibble_in <= 4'(k * 3 + 1);
    endtask

    // reset with pulls p, then exercise each pin group unless p[3] straps detach
    task automatic run_case(input logic [7:0] p, input logic fix);
        int n;
        logic [3:0] last;
        @(posedge core_clk);
        arst_n <= 1'b0;
        strap <= p;
        tx_clk_fix <= fix;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        n = 0;
        while (straps_valid !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check(straps(), p);
        check({rxd_oe, rx_dv_oe, rx_clk_oe, rx_er_oe, col_oe, crs_oe,
            tx_clk_oe}, p[3] ? 8'h00 : 8'h7f);
        @(posedge core_clk);
        strap <= ~p;
        if (!p[3]) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge core_clk);
                {irq_request, col_in, crs_in} <= i[2:0];
                @(posedge core_clk);
                @(negedge core_clk);
                check({irq_out_oe, irq_out_o, col_o, crs_o},
                    {i[2], 1'b0, i[1:0]});
            end
            @(posedge line_clk);
            drive_rx(0);
            // skip a take flagged for data sampled before this drive
            @(negedge line_clk);
            for (int k = 0; k < 6; k++) begin
                n = 0;
                do begin
                    @(negedge line_clk);
                    n++;
                end while (rx_take !== 1'b1 && n < 4);
                check({pins[2], rx_dv_o, rx_er_o, rxd_o[3:1], pins[0]},
                    {1'b0, k != 2, k == 4,
                    (k == 2) ? 4'h0 : 4'(k * 3 + 1)});
                @(posedge line_clk);
                drive_rx(k + 1);
            end
            @(posedge line_clk);
            send <= 1'b1;
            n = 0;
            last = 4'hf;
            repeat (40) begin
                @(negedge line_clk);
                if (tx_nibble_valid === 1'b1) begin
                    n++;
                    check({tx_nibble[0], tx_nibble == last}, 8'h00);
                    last = tx_nibble;
                end
            end
            check(n > 0, !p[7] || fix);
            @(posedge line_clk);
            send <= 1'b0;
        end
        check(straps(), p);
    endtask

    // ************************************
    // main sequence
    // ************************************
    initial begin
        arst_n = 1'b0;
        strap = 8'h00;
        send = 1'b0;
        {col_in, crs_in, irq_request, tx_clk_fix} = 4'h0;
        {rx_nibble_in, rx_valid_in, rx_error_in} = 6'h00;
        err_count = 0;
        n_tests = 0;
        run_case(8'h75, 1'b0);
        run_case(8'h42, 1'b0);
        run_case(8'hc1, 1'b0);
        run_case(8'hc1, 1'b1);
        run_case(8'h0a, 1'b0);
        end_of_test();
    end
endmodule // mii_pins_with_reset_straps_test
